// ===== design/rsc_params.svh
// Offsets, field positions, reset values and timing counts of the reset source controller.
// Assumes inclusion by bare name from the design modules.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RSC_OFS_FLAGS    8'h00
`define RSC_OFS_IPRST0   8'h04
`define RSC_OFS_AIRC     8'h08
`define RSC_OFS_BODCTL   8'h0c
`define RSC_OFS_CLKSEL   8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSC_IPRST_CHIP_BIT  0
`define RSC_IPRST_CORE_BIT  1
`define RSC_AIRC_SYSREQ_BIT 2
`define RSC_FLAG_POR_BIT    0
`define RSC_FLAG_PIN_BIT    1
`define RSC_FLAG_WDT_BIT    2
`define RSC_FLAG_BOD_BIT    4
`define RSC_FLAG_CHIP_BIT   0
`define RSC_FLAG_SYSREQ_BIT 5
`define RSC_FLAG_CORE_BIT   7
`define RSC_FLAG_LOCKUP_BIT 8
`define RSC_CFG_BROWNOUT_ENABLE_BIT   0
`define RSC_CFG_BROWNOUT_LEVEL_LSB   1
`define RSC_CFG_BODRST_BIT  3
`define RSC_CFG_BOOT_BIT    4

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define RSC_FLAGS_W        9
`define RSC_FLAGS_POR_VAL  9'h001
`define RSC_CLKSEL_W       4
`define RSC_CLKSEL_RST     4'h8

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSC_CLK_KHZ        20000
`define RSC_PIN_FILT_NS    36000
`define RSC_PIN_FILT_CYC   ((`RSC_PIN_FILT_NS * `RSC_CLK_KHZ + 999999) / 1000000)
`define RSC_HOLD_CYC       16

`endif

// ===== design/rsc_pkg.sv
// Types shared by the reset source controller modules.
// Assumes the constants header is on the include path.
`default_nettype none

package rsc_pkg;

	// ----------------------------------------
	// Reset sources, in priority order
	// ----------------------------------------
	typedef enum logic [3:0] {
		SRC_NONE,
		SRC_POR,
		SRC_LVR,
		SRC_BOD,
		SRC_PIN,
		SRC_WDT,
		SRC_LOCKUP,
		SRC_CHIP,
		SRC_SYSREQ,
		SRC_CORE
	} rsc_src_t;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HOLD,
		ST_PIN
	} rsc_state_t;

endpackage : rsc_pkg

`default_nettype wire

// ===== design/rsc_sync.sv
// Two-stage synchroniser for asynchronous level inputs.
// Assumes the inputs are slow levels; the first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none

module rsc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : rsc_sync

`default_nettype wire

// ===== design/rsc_pin_filter.sv
// Glitch filter for the external reset pin: the output follows the synchronised
// pin only after it has held a new level for the full filter time.
// Assumes the pin is already synchronised; the output starts high (pin released).
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"

module rsc_pin_filter (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pin level
	input  wire logic pin_n,
	output logic      level_n
);

	localparam int CNT = `RSC_PIN_FILT_CYC;
	localparam logic [10:0] CNT_TOP = 11'(CNT - 1);

	logic [10:0] cnt_q;
	logic [10:0] cnt_d;
	logic        lvl_q;
	logic        lvl_d;

	// A bounce restarts the count, so only a steady level gets through
	always_comb begin
		cnt_d = '0;
		lvl_d = lvl_q;
		if (pin_n != lvl_q) begin
			if (cnt_q == CNT_TOP) begin
				lvl_d = pin_n;
			end else begin
				cnt_d = cnt_q + 11'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			lvl_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			lvl_q <= lvl_d;
		end
	end

	assign level_n = lvl_q;

endmodule : rsc_pin_filter

`default_nettype wire

// ===== design/rsc_ctrl.sv
// Reset source controller: gathers hardware and software reset sources, drives
// the core and peripheral resets, records the source and reloads control fields.
// Assumes it sits in the always-on domain and is itself cleared only by RST.
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"

module rsc_ctrl (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Asynchronous reset sources
	input  wire logic        EXTERNAL_RESET_PIN_N,
	input  wire logic        POWER_ON_DET,
	input  wire logic        LOW_VOLTAGE_DET,
	input  wire logic        BROWNOUT_DET,
	// Synchronous reset sources
	input  wire logic        WDT_TIMEOUT,
	input  wire logic        WWDT_TIMEOUT,
	input  wire logic        CORE_LOCKUP,
	// Configuration
	input  wire logic [31:0] USER_CONFIG_WORD0,
	// Reset outputs
	output logic             CORE_RESET,
	output logic             PERIPH_RESET,
	// Reloaded control fields
	output logic             BROWNOUT_ENABLE,
	output logic [1:0]       BROWNOUT_LEVEL,
	output logic             BROWNOUT_RESET_ENABLE,
	output logic [3:0]       CORE_CLOCK_SELECT,
	output logic             BOOT_SELECT
);

	// ----------------------------------------
	// Input conditioning
	// ----------------------------------------
	logic [2:0] det_s;
	logic       pin_s;
	logic       pin_lvl_n;

	rsc_sync #(.W(3)) u_det_sync (
		.clk      (CORE_CLK),
		.rst      (RST),
		.async_in ({BROWNOUT_DET, LOW_VOLTAGE_DET, POWER_ON_DET}),
		.sync_out (det_s)
	);

	// Pin idles high, so its synchroniser is fed inverted and read back inverted
	rsc_sync #(.W(1)) u_pin_sync (
		.clk      (CORE_CLK),
		.rst      (RST),
		.async_in (~EXTERNAL_RESET_PIN_N),
		.sync_out (pin_s)
	);

	rsc_pin_filter u_pin_filt (
		.clk     (CORE_CLK),
		.rst     (RST),
		.pin_n   (~pin_s),
		.level_n (pin_lvl_n)
	);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Flag update for a source taking effect
	function automatic logic [`RSC_FLAGS_W-1:0] flag_set(
		input rsc_pkg::rsc_src_t src,
		input logic [`RSC_FLAGS_W-1:0] cur
	);
		logic [`RSC_FLAGS_W-1:0] f;
		f = cur;
		unique case (src)
			rsc_pkg::SRC_NONE:   f = cur;
			rsc_pkg::SRC_POR:    f = `RSC_FLAGS_POR_VAL;
			rsc_pkg::SRC_LVR:    f = `RSC_FLAGS_POR_VAL;
			rsc_pkg::SRC_BOD:    f[`RSC_FLAG_BOD_BIT] = 1'b1;
			rsc_pkg::SRC_PIN:    f[`RSC_FLAG_PIN_BIT] = 1'b1;
			rsc_pkg::SRC_WDT:    f[`RSC_FLAG_WDT_BIT] = 1'b1;
			rsc_pkg::SRC_LOCKUP: f[`RSC_FLAG_LOCKUP_BIT] = 1'b1;
			rsc_pkg::SRC_CHIP:   f[`RSC_FLAG_CHIP_BIT] = 1'b1;
			rsc_pkg::SRC_SYSREQ: f[`RSC_FLAG_SYSREQ_BIT] = 1'b1;
			rsc_pkg::SRC_CORE:   f[`RSC_FLAG_CORE_BIT] = 1'b1;
		endcase
		return f;
	endfunction : flag_set

	// Decode of a register offset
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction : hit

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [`RSC_FLAGS_W-1:0]  flags_q, flags_d;
	logic                     chip_req_q, chip_req_d;
	logic                     core_req_q, core_req_d;
	logic                     sys_req_q, sys_req_d;
	logic                     bod_en_q, bod_en_d;
	logic [1:0]               bod_lvl_q, bod_lvl_d;
	logic                     bod_rst_q, bod_rst_d;
	logic [`RSC_CLKSEL_W-1:0] clksel_q, clksel_d;
	logic                     boot_q, boot_d;
	logic [31:0]              prdata_q, prdata_d;
	logic                     pready_q, pready_d;
	logic                     pslverr_q, pslverr_d;

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	rsc_pkg::rsc_state_t state_q, state_d;
	rsc_pkg::rsc_src_t   src;
	logic [4:0]          hold_q, hold_d;
	logic                core_rst_q, core_rst_d;
	logic                peri_rst_q, peri_rst_d;

	logic       setup;
	logic       wr_acc;
	logic       mapped;
	logic [7:0] addr;

	assign setup  = PSEL && !PENABLE;
	assign wr_acc = PSEL && PENABLE && PWRITE && pready_q;
	assign addr   = PADDR;
	assign mapped = hit(addr, `RSC_OFS_FLAGS) || hit(addr, `RSC_OFS_IPRST0) ||
		hit(addr, `RSC_OFS_AIRC) || hit(addr, `RSC_OFS_BODCTL) || hit(addr, `RSC_OFS_CLKSEL);

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	// Hardware sources are levels and win at any time, the pin only outside ST_PIN; software requests are
	// taken only when no reset is in progress, so one request gives one reset
	always_comb begin
		src = rsc_pkg::SRC_NONE;
		if (det_s[0]) begin
			src = rsc_pkg::SRC_POR;
		end else if (det_s[1]) begin
			src = rsc_pkg::SRC_LVR;
		end else if (det_s[2]) begin
			src = rsc_pkg::SRC_BOD;
		end else if (!pin_lvl_n && state_q != rsc_pkg::ST_PIN) begin
			src = rsc_pkg::SRC_PIN;
		end else if (WDT_TIMEOUT || WWDT_TIMEOUT) begin
			src = rsc_pkg::SRC_WDT;
		end else if (CORE_LOCKUP) begin
			src = rsc_pkg::SRC_LOCKUP;
		end else if (state_q == rsc_pkg::ST_IDLE) begin
			if (chip_req_q) begin
				src = rsc_pkg::SRC_CHIP;
			end else if (sys_req_q) begin
				src = rsc_pkg::SRC_SYSREQ;
			end else if (core_req_q) begin
				src = rsc_pkg::SRC_CORE;
			end
		end
	end

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	always_comb begin
		state_d    = state_q;
		hold_d     = hold_q;
		core_rst_d = core_rst_q;
		peri_rst_d = peri_rst_q;
		unique case (state_q)
			rsc_pkg::ST_IDLE: begin
				core_rst_d = 1'b0;
				peri_rst_d = 1'b0;
			end
			rsc_pkg::ST_HOLD: begin
				if (hold_q == 5'h00) begin
					state_d    = rsc_pkg::ST_IDLE;
					core_rst_d = 1'b0;
					peri_rst_d = 1'b0;
				end else begin
					hold_d = hold_q - 5'h01;
				end
			end
			rsc_pkg::ST_PIN: begin
				// Released only after the filter has seen the pin high long enough
				if (pin_lvl_n) begin
					state_d    = rsc_pkg::ST_IDLE;
					core_rst_d = 1'b0;
					peri_rst_d = 1'b0;
				end
			end
		endcase
		if (src != rsc_pkg::SRC_NONE) begin
			core_rst_d = 1'b1;
			peri_rst_d = (src != rsc_pkg::SRC_CORE);
			hold_d     = 5'(`RSC_HOLD_CYC - 1);
			state_d    = (src == rsc_pkg::SRC_PIN) ? rsc_pkg::ST_PIN : rsc_pkg::ST_HOLD;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_q    <= rsc_pkg::ST_IDLE;
			hold_q     <= '0;
			core_rst_q <= 1'b0;
			peri_rst_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			hold_q     <= hold_d;
			core_rst_q <= core_rst_d;
			peri_rst_q <= peri_rst_d;
		end
	end

	// ----------------------------------------
	// Registers and reload
	// ----------------------------------------
	always_comb begin
		flags_d    = flags_q;
		chip_req_d = chip_req_q;
		core_req_d = core_req_q;
		sys_req_d  = sys_req_q;
		bod_en_d   = bod_en_q;
		bod_lvl_d  = bod_lvl_q;
		bod_rst_d  = bod_rst_q;
		clksel_d   = clksel_q;
		boot_d     = boot_q;
		if (wr_acc) begin
			unique case (1'b1)
				hit(addr, `RSC_OFS_FLAGS): begin
					flags_d = flags_q & ~PWDATA[`RSC_FLAGS_W-1:0];
				end
				hit(addr, `RSC_OFS_IPRST0): begin
					chip_req_d = chip_req_q | PWDATA[`RSC_IPRST_CHIP_BIT];
					core_req_d = core_req_q | PWDATA[`RSC_IPRST_CORE_BIT];
				end
				hit(addr, `RSC_OFS_AIRC): begin
					sys_req_d = sys_req_q | PWDATA[`RSC_AIRC_SYSREQ_BIT];
				end
				hit(addr, `RSC_OFS_BODCTL): begin
					bod_en_d  = PWDATA[0];
					bod_lvl_d = PWDATA[2:1];
					bod_rst_d = PWDATA[3];
				end
				hit(addr, `RSC_OFS_CLKSEL): begin
					clksel_d = PWDATA[`RSC_CLKSEL_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// Applied after the clear so an event in the clearing cycle is kept
		if (src != rsc_pkg::SRC_NONE) begin
			flags_d = flag_set(src, flags_d);
			if (src != rsc_pkg::SRC_CORE) begin
				clksel_d = `RSC_CLKSEL_RST;
			end
			if (src != rsc_pkg::SRC_CORE && src != rsc_pkg::SRC_BOD) begin
				bod_en_d  = USER_CONFIG_WORD0[`RSC_CFG_BROWNOUT_ENABLE_BIT];
				bod_lvl_d = USER_CONFIG_WORD0[`RSC_CFG_BROWNOUT_LEVEL_LSB +: 2];
				bod_rst_d = USER_CONFIG_WORD0[`RSC_CFG_BODRST_BIT];
			end
			if (src != rsc_pkg::SRC_CORE && src != rsc_pkg::SRC_SYSREQ) begin
				boot_d = USER_CONFIG_WORD0[`RSC_CFG_BOOT_BIT];
			end
			// A request clears once its reset has been taken
			if (src == rsc_pkg::SRC_CHIP) begin
				chip_req_d = 1'b0;
			end
			if (src == rsc_pkg::SRC_SYSREQ) begin
				sys_req_d = 1'b0;
			end
			if (src == rsc_pkg::SRC_CORE) begin
				core_req_d = 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			flags_q    <= '0;
			chip_req_q <= 1'b0;
			core_req_q <= 1'b0;
			sys_req_q  <= 1'b0;
			bod_en_q   <= 1'b0;
			bod_lvl_q  <= 2'h0;
			bod_rst_q  <= 1'b0;
			clksel_q   <= `RSC_CLKSEL_RST;
			boot_q     <= 1'b0;
		end else begin
			flags_q    <= flags_d;
			chip_req_q <= chip_req_d;
			core_req_q <= core_req_d;
			sys_req_q  <= sys_req_d;
			bod_en_q   <= bod_en_d;
			bod_lvl_q  <= bod_lvl_d;
			bod_rst_q  <= bod_rst_d;
			clksel_q   <= clksel_d;
			boot_q     <= boot_d;
		end
	end

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	// Read data is captured in the setup cycle; every access takes one wait-free
	// access cycle and the answer stands in registers
	always_comb begin
		prdata_d  = 32'h0000_0000;
		pready_d  = setup;
		pslverr_d = setup && !mapped;
		if (setup && !PWRITE) begin
			unique case (1'b1)
				hit(addr, `RSC_OFS_FLAGS):  prdata_d[`RSC_FLAGS_W-1:0] = flags_q;
				hit(addr, `RSC_OFS_IPRST0): prdata_d[1:0] = {core_req_q, chip_req_q};
				hit(addr, `RSC_OFS_AIRC):   prdata_d[`RSC_AIRC_SYSREQ_BIT] = sys_req_q;
				hit(addr, `RSC_OFS_BODCTL): prdata_d[3:0] = {bod_rst_q, bod_lvl_q, bod_en_q};
				hit(addr, `RSC_OFS_CLKSEL): prdata_d[`RSC_CLKSEL_W-1:0] = clksel_q;
				default:                    prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign PRDATA                = prdata_q;
	assign PREADY                = pready_q;
	assign PSLVERR               = pslverr_q;
	assign CORE_RESET            = core_rst_q;
	assign PERIPH_RESET          = peri_rst_q;
	assign BROWNOUT_ENABLE       = bod_en_q;
	assign BROWNOUT_LEVEL        = bod_lvl_q;
	assign BROWNOUT_RESET_ENABLE = bod_rst_q;
	assign CORE_CLOCK_SELECT     = clksel_q;
	assign BOOT_SELECT           = boot_q;

endmodule : rsc_ctrl

`default_nettype wire

// ===== sim/rsc_ctrl_properties.sv
// Port assertions for the reset source controller.
// Assumes it is bound to rsc_ctrl; reads only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module rsc_ctrl_chk (
	// Clock and reset
	input wire logic       CORE_CLK,
	input wire logic       RST,
	// Bus handshake
	input wire logic       PSEL,
	input wire logic       PENABLE,
	input wire logic       PREADY,
	input wire logic       PSLVERR,
	// Sources
	input wire logic       EXTERNAL_RESET_PIN_N,
	input wire logic       POWER_ON_DET,
	input wire logic       WDT_TIMEOUT,
	input wire logic       CORE_LOCKUP,
	// Results
	input wire logic       CORE_RESET,
	input wire logic       PERIPH_RESET,
	input wire logic [3:0] CORE_CLOCK_SELECT
);
	// ----
	// Run-length counters
	// ----
	logic [11:0] low_q;
	logic [11:0] low_d;
	logic [11:0] on_q;
	logic [11:0] on_d;

	always_comb begin
		low_d = EXTERNAL_RESET_PIN_N ? 12'h000 : low_q + 12'h001;
		on_d  = CORE_RESET ? on_q + 12'h001 : 12'h000;
	end

	always_ff @(posedge CORE_CLK) begin
		low_q <= RST ? 12'h000 : low_d;
		on_q  <= RST ? 12'h000 : on_d;
	end

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	a_wdt_full_reset: assert property (WDT_TIMEOUT |=> CORE_RESET && PERIPH_RESET)
		else $error("watchdog left a reset line low");
	a_lockup_full_reset: assert property (CORE_LOCKUP |=> CORE_RESET && PERIPH_RESET)
		else $error("lockup left a reset line low");
	a_periph_has_core: assert property (PERIPH_RESET |-> CORE_RESET)
		else $error("peripheral reset without core reset");
	a_por_full_reset: assert property (POWER_ON_DET [*6] |-> CORE_RESET && PERIPH_RESET)
		else $error("power-on left a reset line low");
	a_pin_long_low: assert property (low_q == 12'h2da |-> PERIPH_RESET)
		else $error("long pin low gave no reset");
	a_hold_length: assert property ($fell(CORE_RESET) |-> on_q >= 12'h010)
		else $error("reset pulse too short");
	a_ready_answer: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready in first access cycle");
	a_ready_one_cycle: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_slverr_with_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
		else $error("error flag outside access");
	a_clksel_on_reset: assert property ($rose(PERIPH_RESET) |-> CORE_CLOCK_SELECT == 4'h8)
		else $error("clock select not reloaded");

endmodule : rsc_ctrl_chk

bind rsc_ctrl rsc_ctrl_chk i_chk (.CORE_CLK, .RST, .PSEL, .PENABLE, .PREADY, .PSLVERR,
	.EXTERNAL_RESET_PIN_N, .POWER_ON_DET, .WDT_TIMEOUT, .CORE_LOCKUP,
	.CORE_RESET, .PERIPH_RESET, .CORE_CLOCK_SELECT);

`default_nettype wire

// ===== sim/rsc_src_model.sv
// Behavioural model of the on-chip hardware reset sources.
// Assumes go is a one-cycle pulse set just after a rising edge.
`timescale 1ns/1ns
`default_nettype none

module rsc_src_model (
	// Clock and command
	input  wire logic              clk,
	input  wire logic              go,
	input  wire logic              alt,
	input  wire rsc_pkg::rsc_src_t src,
	input  wire logic [11:0]       pin_len,
	// Source lines
	output logic                   pin_n,
	output logic                   por,
	output logic                   low_voltage_reset,
	output logic                   brownout_detector,
	output logic                   wdt,
	output logic                   wwdt,
	output logic                   lockup
);
	// Levels other than the pin last 8 cycles so the detectors clear the synchronisers;
	// one process owns every line so each has a single driver
	initial begin
		{pin_n, por, low_voltage_reset, brownout_detector, wdt, wwdt, lockup} <= 7'h40;
		forever begin
			@(posedge clk);
			if (go === 1'b1) begin
				case (src)
					rsc_pkg::SRC_PIN: begin
						pin_n <= 1'b0;
						repeat (pin_len) @(posedge clk);
						pin_n <= 1'b1;
					end
					rsc_pkg::SRC_POR: por <= 1'b1;
					rsc_pkg::SRC_LVR: low_voltage_reset <= 1'b1;
					rsc_pkg::SRC_BOD: brownout_detector <= 1'b1;
					rsc_pkg::SRC_WDT: {wwdt, wdt} <= alt ? 2'h2 : 2'h1;
					rsc_pkg::SRC_LOCKUP: lockup <= 1'b1;
					default: ;
				endcase
				repeat (8) @(posedge clk);
				{por, low_voltage_reset, brownout_detector, wdt, wwdt, lockup} <= 6'h00;
			end
		end
	end

endmodule : rsc_src_model

`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the reset source controller.
// Assumes the source model drives the hardware lines; bus tasks speak APB.
`timescale 1ns/1ns
`default_nettype none

module tb;
	typedef struct packed {
		rsc_pkg::rsc_src_t src;
		logic [8:0]        flags;
		logic              periph;
	} rsc_row_t;

	logic        CORE_CLK = 1'b0;
	logic        RST      = 1'b1;
	logic        PSEL     = 1'b0;
	logic        PENABLE  = 1'b0;
	logic        PWRITE   = 1'b0;
	logic [7:0]  PADDR    = 8'h00;
	logic [31:0] PWDATA   = 32'h0;
	logic [31:0] USER_CONFIG_WORD0 = 32'h0;
	logic [31:0] PRDATA;
	logic        PREADY, PSLVERR, CORE_RESET, PERIPH_RESET;
	logic        BROWNOUT_ENABLE, BROWNOUT_RESET_ENABLE, BOOT_SELECT;
	logic [1:0]  BROWNOUT_LEVEL;
	logic [3:0]  CORE_CLOCK_SELECT;
	logic        EXTERNAL_RESET_PIN_N, POWER_ON_DET, LOW_VOLTAGE_DET, BROWNOUT_DET;
	logic        WDT_TIMEOUT, WWDT_TIMEOUT, CORE_LOCKUP;
	logic        go  = 1'b0;
	logic        alt = 1'b0;
	logic [11:0] pin_len = 12'h0;
	rsc_pkg::rsc_src_t src = rsc_pkg::SRC_NONE;
	logic [31:0] rd;
	logic        err;
	int          failures = 0;
	int          total_checks = 0;
	rsc_row_t    rows [10] = '{'{rsc_pkg::SRC_POR, 9'h001, 1'b1},
		'{rsc_pkg::SRC_LVR, 9'h001, 1'b1}, '{rsc_pkg::SRC_BOD, 9'h010, 1'b1},
		'{rsc_pkg::SRC_PIN, 9'h002, 1'b1}, '{rsc_pkg::SRC_WDT, 9'h004, 1'b1},
		'{rsc_pkg::SRC_WDT, 9'h004, 1'b1}, '{rsc_pkg::SRC_LOCKUP, 9'h100, 1'b1},
		'{rsc_pkg::SRC_CHIP, 9'h001, 1'b1}, '{rsc_pkg::SRC_SYSREQ, 9'h020, 1'b1},
		'{rsc_pkg::SRC_CORE, 9'h080, 1'b0}};

	always #25 CORE_CLK = ~CORE_CLK;

	rsc_ctrl i_dut (.*);

	rsc_src_model i_src (.clk(CORE_CLK), .go(go), .alt(alt), .src(src), .pin_len(pin_len),
		.pin_n(EXTERNAL_RESET_PIN_N), .por(POWER_ON_DET), .low_voltage_reset(LOW_VOLTAGE_DET),
		.brownout_detector(BROWNOUT_DET), .wdt(WDT_TIMEOUT), .wwdt(WWDT_TIMEOUT), .lockup(CORE_LOCKUP));

	task automatic results;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	task automatic die;
		failures++;
		results();
	endtask : die

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until ready is seen at a rising edge; answer taken and
	// request released at that same edge, before its updates land
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge CORE_CLK);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= wd;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge CORE_CLK);
			if (PREADY === 1'b1) break;
		end
		rd      = PRDATA;
		err     = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		if (n == 16) die();
	endtask : apb

	task automatic fire(input rsc_pkg::rsc_src_t s, input logic [11:0] len);
		@(posedge CORE_CLK);
		src     <= s;
		pin_len <= len;
		go      <= 1'b1;
		@(posedge CORE_CLK);
		go      <= 1'b0;
	endtask : fire

	task automatic wait_rst(output logic p);
		int n;
		for (n = 0; n < 900 && CORE_RESET !== 1'b1; n++) @(negedge CORE_CLK);
		if (CORE_RESET !== 1'b1) die();
		p = PERIPH_RESET;
		for (n = 0; n < 3000 && CORE_RESET !== 1'b0; n++) @(negedge CORE_CLK);
		if (n == 3000) die();
	endtask : wait_rst

	initial begin
		rsc_row_t r;
		logic     p;
		logic     boot_e;
		logic     seen;
		logic     keep;
		repeat (12) @(posedge CORE_CLK);
		RST <= 1'b0;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		chk({28'h0, CORE_CLOCK_SELECT}, 32'h8);
		chk({30'h0, CORE_RESET, PERIPH_RESET}, 32'h0);
		$display("test reset values done");
		boot_e = 1'b0;
		for (int i = 0; i < 10; i++) begin
			r = rows[i];
			USER_CONFIG_WORD0 <= {27'h0, i[0], 4'hf};
			alt <= (i == 5);
			apb(1'b1, 8'h00, 32'h1ff);
			apb(1'b1, 8'h0c, 32'h8);
			apb(1'b1, 8'h10, 32'h3);
			if (r.src == rsc_pkg::SRC_CHIP) apb(1'b1, 8'h04, 32'h1);
			else if (r.src == rsc_pkg::SRC_SYSREQ) apb(1'b1, 8'h08, 32'h4);
			else if (r.src == rsc_pkg::SRC_CORE) apb(1'b1, 8'h04, 32'h2);
			else fire(r.src, 12'h2f8);
			wait_rst(p);
			chk({31'h0, p}, {31'h0, r.periph});
			apb(1'b0, 8'h00, 32'h0);
			chk(rd, {23'h0, r.flags});
			keep = (r.src == rsc_pkg::SRC_BOD) || (r.src == rsc_pkg::SRC_CORE);
			chk({28'h0, BROWNOUT_RESET_ENABLE, BROWNOUT_LEVEL, BROWNOUT_ENABLE},
				keep ? 32'h8 : 32'hf);
			chk({28'h0, CORE_CLOCK_SELECT}, r.periph ? 32'h8 : 32'h3);
			if (r.src != rsc_pkg::SRC_SYSREQ && r.src != rsc_pkg::SRC_CORE) boot_e = i[0];
			chk({31'h0, BOOT_SELECT}, {31'h0, boot_e});
			apb(1'b0, 8'h04, 32'h0);
			chk(rd, 32'h0);
			apb(1'b0, 8'h08, 32'h0);
			chk(rd, 32'h0);
			$display("test source row %0d done", i);
		end
		// Short pin glitch must be filtered out
		fire(rsc_pkg::SRC_PIN, 12'h12c);
		seen = 1'b0;
		repeat (1100) begin
			@(negedge CORE_CLK);
			seen = seen | CORE_RESET;
		end
		chk({31'h0, seen}, 32'h0);
		$display("test pin glitch done");
		apb(1'b1, 8'h00, 32'h1ff);
		fire(rsc_pkg::SRC_POR, 12'h0);
		wait_rst(p);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		$display("test power-on flag clear done");
		apb(1'b1, 8'h40, 32'hffffffff);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test unmapped address done");
		// Mid-run reset must bring the control fields back to their reset values
		apb(1'b1, 8'h10, 32'h3);
		RST <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		RST <= 1'b0;
		chk({28'h0, CORE_CLOCK_SELECT}, 32'h8);
		chk({28'h0, BROWNOUT_RESET_ENABLE, BROWNOUT_LEVEL, BROWNOUT_ENABLE}, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h8);
		$display("test mid-run reset done");
		results();
	end

endmodule : tb

`default_nettype wire
